// [ddsw_params.svh]
// Constants shared by both ends of the serial word loader
`ifndef DDSW_PARAMS_SVH
`define DDSW_PARAMS_SVH

// ----------------------------------------
// Serial word
// ----------------------------------------
`define DDSW_WORD_BITS      16
`define DDSW_ADDR_CTRL      2'h0
`define DDSW_ADDR_TWA       2'h1
`define DDSW_ADDR_TWB       2'h2
`define DDSW_ADDR_PHASE     2'h3
`define DDSW_PHASE_SEL_BIT  13

// ----------------------------------------
// Mode setup word fields
// ----------------------------------------
`define DDSW_CTL_PAIR       13
`define DDSW_CTL_HALF       12
`define DDSW_CTL_TSEL       11
`define DDSW_CTL_PSEL       10
`define DDSW_CTL_SRC        9
`define DDSW_CTL_RESET      8
`define DDSW_CTL_CSLEEP     7
`define DDSW_CTL_DSLEEP     6
`define DDSW_CTL_BITEN      5
`define DDSW_CTL_SIGN       4
`define DDSW_CTL_HALVE_MSB_OUTPUT       3
`define DDSW_CTL_MODE       1
`define DDSW_CTL_RESET_VAL  14'h0000

// ----------------------------------------
// Latency and timing
// ----------------------------------------
`define DDSW_PIPE_CYCLES    8
`define DDSW_CLK_NS         100
`define DDSW_SCLK_HALF_NS   200
`define DDSW_SCLK_HALF_CYC  \
  ((`DDSW_SCLK_HALF_NS + `DDSW_CLK_NS - 1) / `DDSW_CLK_NS)

// ----------------------------------------
// Controller APB registers
// ----------------------------------------
`define DDSW_REG_TX         12'h000
`define DDSW_REG_CTRL       12'h004
`define DDSW_REG_STATUS     12'h008
`define DDSW_CTRL_HOLD      0
`define DDSW_CTRL_RSTPIN    1
`define DDSW_CTRL_SLEEPPIN  2
`define DDSW_CTRL_TSELPIN   3
`define DDSW_CTRL_PSELPIN   4
`define DDSW_CTRL_RESET_VAL 5'h02
`define DDSW_STAT_BUSY      0
`define DDSW_STAT_FRAMED    1
`define DDSW_STAT_CNT_LSB   8

`endif

// [ddsw_pkg.sv]
// Types shared by both ends of the serial word loader
`include "ddsw_params.svh"

package ddsw_pkg;

  typedef logic [`DDSW_PIPE_CYCLES-1:0][39:0] ddsw_pipe_t;

  typedef struct packed {
    logic        sclk_q;
    logic [3:0]  bit_cnt;
    logic [15:0] shreg;
    logic [15:0] last_word;
    logic        word_strobe;
    logic [13:0] ctl;
    logic [13:0] ctl_neg;
    logic [27:0] tw_a;
    logic [27:0] tw_b;
    logic [11:0] ph_a;
    logic [11:0] ph_b;
    logic        pair_pending;
    logic [1:0]  pair_addr;
    logic [13:0] pair_low;
    logic [1:0]  sel_prev;
    logic        rst_neg;
    logic        conv_sleep;
    logic [3:0]  run_cnt;
    logic        run;
    ddsw_pipe_t  pipe;
  } ddsw_dev_state_t;

  typedef enum logic [1:0] {
    DDSW_IDLE = 2'b00,
    DDSW_HIGH = 2'b01,
    DDSW_LOW  = 2'b10,
    DDSW_HOLD = 2'b11
  } ddsw_mst_fsm_t;

  typedef struct packed {
    ddsw_mst_fsm_t fsm;
    logic [7:0]    div_cnt;
    logic [3:0]    bit_cnt;
    logic [15:0]   shreg;
    logic          sclk;
    logic          frame_sync_n;
    logic          sdata;
    logic          pending;
    logic [15:0]   tx_word;
    logic [4:0]    ctrl;
    logic [7:0]    sent_cnt;
    logic [31:0]   prdata;
  } ddsw_mst_state_t;

endpackage : ddsw_pkg

// [ddsw_if.sv]
// Serial link and control pins between controller and device
`timescale 1ns/1ps
`default_nettype none

interface ddsw_if;
  logic sclk;
  logic frame_sync_n;
  logic sdata;
  logic tuning_select_pin;
  logic offset_select_pin;
  logic reset_pin;
  logic sleep_pin;

  modport dev (
    input sclk,
    input frame_sync_n,
    input sdata,
    input tuning_select_pin,
    input offset_select_pin,
    input reset_pin,
    input sleep_pin
  );

  modport mst (
    output sclk,
    output frame_sync_n,
    output sdata,
    output tuning_select_pin,
    output offset_select_pin,
    output reset_pin,
    output sleep_pin
  );
endinterface : ddsw_if

`default_nettype wire

// [ddsw_device.sv]
// Device end: serial word loader with register decode and latency
`timescale 1ns/1ps
`default_nettype none
`include "ddsw_params.svh"

// Contract
// - Every transfer is a 16-bit serial word
// - Frame sync high: serial data ignored
// - Shift on falling serial clock, 16 pulses
// - Frame may stay low for streamed words
// - Master holds serial clock high at frame start
// - Reset clears synth state, keeps registers
// - Master holds reset while loading registers
// - Output starts eight cycles after reset release
// - Select pin latency eight, late adds one
// - Register load reaches output in 8-9 cycles
// - Reset and sleep release sampled late
// - Control bits sampled late, except mode, pair and half select
// - Top bits zero write mode setup word
// - Pair mode: low half, then high half
// - Pair mode updates only after both halves
// - Master repeats one register for full loads
// - Split mode writes one 14-bit half
// - Half select ignored in pair mode
// - Half select one high, zero low
// - Tuning select bit picks word b
// - Source bit: pins or control bits
module ddsw_device (
  input  wire logic        pclk,
  input  wire logic        presetn,
  ddsw_if.dev              link,
  input  wire logic        select_pin_late,
  output logic [27:0]      active_tuning_word,
  output logic [11:0]      active_phase_word,
  output logic             synth_reset,
  output logic             output_run,
  output logic             clock_sleep,
  output logic             converter_sleep,
  output logic             bit_output_enable,
  output logic             sign_or_msb_select,
  output logic             halve_msb_output,
  output logic             wave_mode,
  output logic             word_strobe,
  output logic [15:0]      last_word
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [27:0] ddsw_half_put(
    input logic [27:0] old,
    input logic [13:0] val,
    input logic        hi
  );
    return hi ? {val, old[13:0]} : {old[27:14], val};
  endfunction : ddsw_half_put

  ddsw_pkg::ddsw_dev_state_t s;
  ddsw_pkg::ddsw_dev_state_t next_s;

  logic [15:0] word;
  logic        fall;
  logic [27:0] cur;
  logic [27:0] nv;
  logic        wr;
  logic        src;
  logic [1:0]  pin_sel;
  logic        tsel;
  logic        psel;
  logic        eff_rst;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    word = {s.shreg[14:0], link.sdata};
    fall = s.sclk_q & ~link.sclk;
    cur = 28'h0000000;
    nv = 28'h0000000;
    wr = 1'b0;
    next_s.word_strobe = 1'b0;
    next_s.sclk_q = link.sclk;

    // Serial side
    if (link.frame_sync_n) begin
      next_s.bit_cnt = 4'h0;
    end else if (fall) begin
      next_s.shreg = word;
      // Counter wraps so held frames stream words
      next_s.bit_cnt = s.bit_cnt + 4'h1;
      if (s.bit_cnt == 4'hf) begin
        next_s.word_strobe = 1'b1;
        next_s.last_word = word;
        unique case (word[15:14])
          `DDSW_ADDR_CTRL: begin
            next_s.ctl = word[13:0];
            next_s.pair_pending = 1'b0;
          end
          `DDSW_ADDR_TWA, `DDSW_ADDR_TWB: begin
            cur = (word[15:14] == `DDSW_ADDR_TWB) ? s.tw_b : s.tw_a;
            if (s.ctl[`DDSW_CTL_PAIR]) begin
              if (s.pair_pending && s.pair_addr == word[15:14]) begin
                nv = ddsw_half_put(cur, s.pair_low, 1'b0);
                nv = ddsw_half_put(nv, word[13:0], 1'b1);
                wr = 1'b1;
                next_s.pair_pending = 1'b0;
              end else begin
                // First half parked, register untouched
                next_s.pair_pending = 1'b1;
                next_s.pair_addr = word[15:14];
                next_s.pair_low = word[13:0];
              end
            end else begin
              nv = ddsw_half_put(cur, word[13:0], s.ctl[`DDSW_CTL_HALF]);
              wr = 1'b1;
              next_s.pair_pending = 1'b0;
            end
            if (wr && word[15:14] == `DDSW_ADDR_TWB) begin
              next_s.tw_b = nv;
            end else if (wr) begin
              next_s.tw_a = nv;
            end
          end
          `DDSW_ADDR_PHASE: begin
            if (word[`DDSW_PHASE_SEL_BIT]) begin
              next_s.ph_b = word[11:0];
            end else begin
              next_s.ph_a = word[11:0];
            end
          end
        endcase
      end
    end

    // Late sampling stage, one cycle behind the serial side
    next_s.ctl_neg = s.ctl;
    src = s.ctl_neg[`DDSW_CTL_SRC];
    next_s.sel_prev = {link.tuning_select_pin, link.offset_select_pin};
    // A pin change outside its window lands one cycle later
    pin_sel = select_pin_late ? s.sel_prev
                              : {link.tuning_select_pin, link.offset_select_pin};
    tsel = src ? pin_sel[1] : s.ctl_neg[`DDSW_CTL_TSEL];
    psel = src ? pin_sel[0] : s.ctl_neg[`DDSW_CTL_PSEL];
    eff_rst = src ? link.reset_pin : s.ctl_neg[`DDSW_CTL_RESET];
    next_s.rst_neg = eff_rst;
    next_s.conv_sleep = src ? link.sleep_pin
                            : s.ctl_neg[`DDSW_CTL_DSLEEP];

    // Output pipeline
    next_s.pipe[0] = {tsel ? s.tw_b : s.tw_a,
                      psel ? s.ph_b : s.ph_a};
    for (int i = 1; i < `DDSW_PIPE_CYCLES; i++) begin
      next_s.pipe[i] = s.pipe[i-1];
    end

    // Run-up after reset; registers stay untouched
    if (s.rst_neg) begin
      next_s.run_cnt = 4'h0;
      next_s.run = 1'b0;
    end else if (!s.run) begin
      next_s.run_cnt = s.run_cnt + 4'h1;
      next_s.run = (s.run_cnt == 4'(`DDSW_PIPE_CYCLES - 2));
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign active_tuning_word = s.pipe[`DDSW_PIPE_CYCLES-1][39:12];
  assign active_phase_word  = s.pipe[`DDSW_PIPE_CYCLES-1][11:0];
  assign synth_reset        = s.rst_neg;
  assign output_run         = s.run;
  assign clock_sleep        = s.ctl_neg[`DDSW_CTL_CSLEEP];
  assign converter_sleep    = s.conv_sleep;
  assign bit_output_enable  = s.ctl_neg[`DDSW_CTL_BITEN];
  assign sign_or_msb_select = s.ctl_neg[`DDSW_CTL_SIGN];
  assign halve_msb_output   = s.ctl_neg[`DDSW_CTL_HALVE_MSB_OUTPUT];
  // Mode bit bypasses the late stage
  assign wave_mode          = s.ctl[`DDSW_CTL_MODE];
  assign word_strobe        = s.word_strobe;
  assign last_word          = s.last_word;

endmodule : ddsw_device

`default_nettype wire

// [ddsw_master.sv]
// Controller end: APB slave that sends 16-bit words to the device
`timescale 1ns/1ps
`default_nettype none
`include "ddsw_params.svh"

module ddsw_master #(
  parameter int SCLK_HALF = `DDSW_SCLK_HALF_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  ddsw_if.mst              link
);

  ddsw_pkg::ddsw_mst_state_t s;
  ddsw_pkg::ddsw_mst_state_t next_s;

  logic hit_tx;
  logic hit_ctrl;
  logic hit_stat;
  logic acc;
  logic half_done;
  logic busy;

  assign hit_tx   = (paddr == `DDSW_REG_TX);
  assign hit_ctrl = (paddr == `DDSW_REG_CTRL);
  assign hit_stat = (paddr == `DDSW_REG_STATUS);
  assign acc      = psel & penable;
  assign busy     = s.pending | (s.fsm == ddsw_pkg::DDSW_HIGH)
                  | (s.fsm == ddsw_pkg::DDSW_LOW);
  // A word write stalls while the previous word still waits
  assign pready   = ~(acc & pwrite & hit_tx & s.pending);
  assign pslverr  = acc & ~(hit_tx | hit_ctrl | hit_stat);
  assign half_done = (s.div_cnt == 8'(SCLK_HALF - 1));

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    if (psel && !penable) begin
      next_s.prdata = 32'h00000000;
      if (hit_tx) begin
        next_s.prdata[15:0] = s.tx_word;
      end else if (hit_ctrl) begin
        next_s.prdata[4:0] = s.ctrl;
      end else if (hit_stat) begin
        next_s.prdata[`DDSW_STAT_BUSY] = busy;
        next_s.prdata[`DDSW_STAT_FRAMED] = ~s.frame_sync_n;
        next_s.prdata[`DDSW_STAT_CNT_LSB +: 8] = s.sent_cnt;
      end
    end

    // Serial engine; data moves on rising edges, device samples falling
    next_s.div_cnt = half_done ? 8'h00 : s.div_cnt + 8'h01;
    unique case (s.fsm)
      ddsw_pkg::DDSW_IDLE, ddsw_pkg::DDSW_HOLD: begin
        next_s.div_cnt = 8'h00;
        if (s.pending) begin
          // Clock is high here when the frame opens
          next_s.frame_sync_n = 1'b0;
          next_s.shreg = s.tx_word;
          next_s.sdata = s.tx_word[15];
          next_s.bit_cnt = 4'h0;
          next_s.pending = 1'b0;
          next_s.fsm = ddsw_pkg::DDSW_HIGH;
        end else if (!s.ctrl[`DDSW_CTRL_HOLD]) begin
          next_s.frame_sync_n = 1'b1;
          next_s.fsm = ddsw_pkg::DDSW_IDLE;
        end
      end
      ddsw_pkg::DDSW_HIGH: begin
        if (half_done) begin
          next_s.sclk = 1'b0;
          next_s.fsm = ddsw_pkg::DDSW_LOW;
        end
      end
      ddsw_pkg::DDSW_LOW: begin
        if (half_done) begin
          next_s.sclk = 1'b1;
          if (s.bit_cnt == 4'hf) begin
            next_s.sent_cnt = s.sent_cnt + 8'h01;
            // Held frame streams the next word with no gap
            next_s.fsm = ddsw_pkg::DDSW_HOLD;
            next_s.frame_sync_n = ~s.ctrl[`DDSW_CTRL_HOLD];
            if (!s.ctrl[`DDSW_CTRL_HOLD]) begin
              next_s.fsm = ddsw_pkg::DDSW_IDLE;
            end
          end else begin
            next_s.bit_cnt = s.bit_cnt + 4'h1;
            next_s.shreg = {s.shreg[14:0], 1'b0};
            next_s.sdata = s.shreg[14];
            next_s.fsm = ddsw_pkg::DDSW_HIGH;
          end
        end
      end
    endcase

    // Register writes; a word is only taken when none waits
    if (acc && pready && pwrite) begin
      if (hit_tx) begin
        next_s.tx_word = pwdata[15:0];
        next_s.pending = 1'b1;
      end else if (hit_ctrl) begin
        next_s.ctrl = pwdata[4:0];
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{fsm: ddsw_pkg::DDSW_IDLE, sclk: 1'b1, frame_sync_n: 1'b1,
             ctrl: `DDSW_CTRL_RESET_VAL, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata                 = s.prdata;
  assign link.sclk              = s.sclk;
  assign link.frame_sync_n      = s.frame_sync_n;
  assign link.sdata             = s.sdata;
  assign link.reset_pin         = s.ctrl[`DDSW_CTRL_RSTPIN];
  assign link.sleep_pin         = s.ctrl[`DDSW_CTRL_SLEEPPIN];
  assign link.tuning_select_pin = s.ctrl[`DDSW_CTRL_TSELPIN];
  assign link.offset_select_pin = s.ctrl[`DDSW_CTRL_PSELPIN];

endmodule : ddsw_master

`default_nettype wire

// [ddsw_sva.sv]
// Checker for the serial link between controller and device
`timescale 1ns/1ps
`default_nettype none

module ddsw_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        sclk,
  input wire logic        frame_sync_n,
  input wire logic        sdata,
  input wire logic        word_strobe,
  input wire logic [15:0] last_word,
  input wire logic        synth_reset,
  input wire logic        output_run
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // Reference shifter
  // ----------------------------------------
  logic        sclk_d;
  logic [3:0]  falls;
  logic [15:0] sh;

  // Counts wrap at 16, so a whole word reads as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d <= 1'b1;
      falls  <= 4'h0;
      sh     <= 16'h0000;
    end else begin
      sclk_d <= sclk;
      if (frame_sync_n) begin
        falls <= 4'h0;
      end else if (sclk_d && !sclk) begin
        falls <= falls + 4'h1;
        sh    <= {sh[14:0], sdata};
      end
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_sclk_idle_high: assert property (frame_sync_n |-> sclk)
    else $error("serial clock low outside a frame");
  a_start_clk_high: assert property ($fell(frame_sync_n) |-> sclk)
    else $error("frame started with serial clock low");
  a_data_held_low: assert property (
    (!frame_sync_n && !sclk && !sclk_d) |-> $stable(sdata))
    else $error("serial data moved while clock low");
  a_strobe_one_cycle: assert property (word_strobe |=> !word_strobe)
    else $error("word strobe longer than one cycle");
  a_strobe_in_frame: assert property (word_strobe |-> !$past(frame_sync_n, 3))
    else $error("word taken without frame");
  a_strobe_after_16: assert property (word_strobe |-> falls == 4'h0)
    else $error("word taken before 16 falls");
  a_frame_whole_words: assert property ($rose(frame_sync_n) |-> falls == 4'h0)
    else $error("frame ended mid word");
  a_strobe_word_match: assert property (word_strobe |-> ##1 last_word == sh)
    else $error("received word differs from line");
  // Run rises seven samples after the late reset stage clears
  a_run_after_reset: assert property (
    $fell(synth_reset) |-> !output_run [*7] ##1 output_run)
    else $error("output start latency wrong");
  a_run_stops_reset: assert property ($rose(synth_reset) |-> ##[0:2] !output_run)
    else $error("output kept running in reset");
endmodule : ddsw_sva

`default_nettype wire

// [testbench.sv]
// Testbench joining controller and device over the serial link
`timescale 1ns/1ps
`default_nettype none
`include "ddsw_params.svh"

module testbench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        select_pin_late = 1'b0;
  logic [27:0] tw;
  logic [11:0] pw;
  logic        sr, run, cs, ds, be, sg, hv, wm, ws;
  logic [15:0] lw;
  logic [31:0] rd;
  logic        err;
  int          num_errors = 0;
  int          checked = 0;
  int          sent = 0;
  int          n;

  always #50 pclk = ~pclk;

  ddsw_if link_if ();
  ddsw_master ddsw_master_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .link(link_if));
  ddsw_device ddsw_device_i (.pclk, .presetn, .link(link_if), .select_pin_late,
    .active_tuning_word(tw), .active_phase_word(pw), .synth_reset(sr), .output_run(run),
    .clock_sleep(cs), .converter_sleep(ds), .bit_output_enable(be), .sign_or_msb_select(sg),
    .halve_msb_output(hv), .wave_mode(wm), .word_strobe(ws), .last_word(lw));
  ddsw_sva ddsw_sva_i (.pclk, .presetn, .sclk(link_if.sclk),
    .frame_sync_n(link_if.frame_sync_n), .sdata(link_if.sdata), .word_strobe(ws),
    .last_word(lw), .synth_reset(sr), .output_run(run));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    // A word write stalls while an earlier word still waits, for up to one frame
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 3000);
    if (k >= 3000) begin
      num_errors++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic idle();
    int k;
    k = 0;
    do begin
      apb(1'b0, `DDSW_REG_STATUS, 32'h0);
      k++;
    end while (rd[`DDSW_STAT_BUSY] !== 1'b0 && k < 100);
    if (k >= 100) begin
      num_errors++;
      finish_test();
    end
    // Pipe of eight plus late stage and start delay
    repeat (16) @(posedge pclk);
  endtask : idle

  task automatic send(input logic [15:0] w);
    apb(1'b1, `DDSW_REG_TX, 32'(w));
    sent++;
    idle();
  endtask : send

  // Counts edges until the output word leaves its old value
  task automatic wait_tw(input logic [27:0] old);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (tw === old && n < 40);
    if (n >= 40) begin
      num_errors++;
      finish_test();
    end
  endtask : wait_tw

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `DDSW_REG_CTRL, 32'h0);
    chk(rd, 32'(`DDSW_CTRL_RESET_VAL));
    apb(1'b0, 12'h00c, 32'h0);
    chk(32'({err, rd[0]}), 32'h2);
    for (int i = 0; i < 6; i++) begin
      send(16'h0001 << ((i < 5) ? 7 - i : 1));
      chk(32'({cs, ds, be, sg, hv, wm}), 32'h20 >> i);
    end
    send(16'h0000);
    send({2'b01, 14'h1234});
    chk(32'(tw), 32'(28'h0001234));
    send(16'h1000);
    send({2'b01, 14'h0abc});
    chk(32'(tw), 32'({14'h0abc, 14'h1234}));
    send({2'b11, 2'b00, 12'h5a5});
    chk(32'(pw), 32'h5a5);
    send({2'b11, 2'b10, 12'h3c3});
    chk(32'(pw), 32'h5a5);
    send(16'h3800);
    send({2'b10, 14'h0111});
    chk(32'(tw), 32'h0);
    apb(1'b1, `DDSW_REG_TX, 32'({2'b10, 14'h0222}));
    sent++;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (ws !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      num_errors++;
      finish_test();
    end
    wait_tw(28'h0);
    chk(32'(n >= 8 && n <= 9), 32'h1);
    chk(32'(tw), 32'({14'h0222, 14'h0111}));
    idle();
    send(16'h0900);
    chk(32'({sr, run}), 32'h2);
    send(16'h0800);
    chk(32'({sr, run, tw}), 32'({2'b01, 14'h0222, 14'h0111}));
    send(16'h0200);
    chk(32'({sr, tw}), 32'({1'b1, 14'h0abc, 14'h1234}));
    // Pins move one edge after the write, so one edge is taken off
    select_pin_late <= 1'b1;
    apb(1'b1, `DDSW_REG_CTRL, 32'h1c);
    wait_tw({14'h0abc, 14'h1234});
    chk(32'(n - 1), 32'(`DDSW_PIPE_CYCLES + 1));
    chk(32'({sr, ds, tw}), 32'({2'b01, 14'h0222, 14'h0111}));
    chk(32'(pw), 32'h3c3);
    select_pin_late <= 1'b0;
    apb(1'b1, `DDSW_REG_CTRL, 32'h01);
    wait_tw({14'h0222, 14'h0111});
    chk(32'(n - 1), 32'(`DDSW_PIPE_CYCLES));
    chk(32'(tw), 32'({14'h0abc, 14'h1234}));
    apb(1'b1, `DDSW_REG_TX, 32'h0000);
    apb(1'b1, `DDSW_REG_TX, 32'({2'b01, 14'h0055}));
    sent += 2;
    idle();
    chk(32'(lw), 32'h4055);
    chk(32'(tw), 32'({14'h0abc, 14'h0055}));
    chk(32'({rd[`DDSW_STAT_FRAMED], rd[15:8]}), 32'({1'b1, 8'(sent)}));
    apb(1'b1, `DDSW_REG_CTRL, 32'h00);
    repeat (4) @(posedge pclk);
    chk(32'(link_if.frame_sync_n), 32'h1);
    finish_test();
  end
endmodule : testbench

`default_nettype wire
